// *** core/hsm_deglitch.sv ***
/*
 * Asymmetric deglitch filter: the output follows its target only after
 * the target has held for the rise or fall count. Assumes a synchronous
 * target on clk.
 */
`timescale 1ns/1ps
`include "hsm_params.svh"

module hsm_deglitch
    import hsm_pkg::*;
#(
    parameter int unsigned RISE_CYC = 1,
    parameter int unsigned FALL_CYC = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Filter
    input wire logic target,
    output logic level
);

    hsm_degl_t q;
    hsm_degl_t d;
    logic [`HSM_DEGL_W-1:0] limit;

    // A mismatch that breaks early restarts the count from zero
    always_comb begin
        d = q;
        limit = q.level ? `HSM_DEGL_W'(FALL_CYC - 1) : `HSM_DEGL_W'(RISE_CYC - 1);
        if (target == q.level) begin
            d.cnt = '0;
        end else if (q.cnt >= limit) begin
            d.cnt = '0;
            d.level = target;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.level;

endmodule : hsm_deglitch

// *** core/hsm_params.svh ***
/*
 * Named constants of the hot swap mode sequencer: clock rate, printed
 * times with their derived cycle counts, timer steps and counter widths.
 * Assumes an including file that needs only macros; no logic lives here.
 */
// How it works
// RULE_01: Inrush timer charges in inrush while limiting, discharges otherwise.
// RULE_02: Fault timer charges in regular operation while over current limit, else discharges.
// RULE_03: Either timer at threshold declares timeout; latch variants latch, retry variant retries.
// RULE_04: Fast trip pulls the gate down at once, no timer involved.
// RULE_05: After fast trip: latch restarts once, retry keeps retrying, fast-latch never retries.
// RULE_06: Fast trip in regular mode gives a fixed-length strong gate pull-down pulse.
// RULE_07: After that pulse fast-latch goes latched; latch and retry return to inrush.
// RULE_08: Power-good rises after rise deglitch when enabled and drain-source voltage low.
// RULE_09: Power-good falls after fall deglitch on disable, high drain-source or timeout; the code clears it on fault timer timeout only (oc_tripped).
// RULE_10: Fault output low on shorted FET while disabled, timer timeout or over-temperature.
// RULE_11: After reset the state machine starts in inrush mode.
// RULE_12: Inrush regulates the gate; on timeout gate off, then latched or retry.
// RULE_13: Regular mode keeps timers discharged, gate on; over current limit enters fault mode.
// RULE_14: Fault mode runs fault timer; clears to regular; expiry goes latched or retry.
// RULE_15: Latched holds gate off, fault on; only enable rising edge restarts inrush.
// RULE_16: Retry mode runs sixty-four inrush timer cycles, then tries inrush again.
// RULE_17: Overvoltage turns the pass transistor off.
// RULE_18: Fault output deglitched on both edges, a few milliseconds.
// RULE_19: Variant is a static parameter; timers are counters with parameter timeouts.
// RULE_20: All comparator inputs are synchronised before use.
`ifndef HSM_PARAMS_SVH
`define HSM_PARAMS_SVH

// Clock rate
`define HSM_CLK_MHZ 250
// Strong pull-down pulse, printed in microseconds
`define HSM_PD_PULSE_US 63
`define HSM_PD_PULSE_CYC (`HSM_PD_PULSE_US * `HSM_CLK_MHZ)
// Power-good deglitch, printed in milliseconds
`define HSM_PG_RISE_MS 1
`define HSM_PG_FALL_MS 8
`define HSM_PG_RISE_CYC (`HSM_PG_RISE_MS * 1000 * `HSM_CLK_MHZ)
`define HSM_PG_FALL_CYC (`HSM_PG_FALL_MS * 1000 * `HSM_CLK_MHZ)
// Fault deglitch 3.9 ms, kept in microseconds to stay integral
`define HSM_FLT_DEGL_US 3900
`define HSM_FLT_DEGL_CYC (`HSM_FLT_DEGL_US * `HSM_CLK_MHZ)
// Timer model: source 10.25 uA vs sink 2 uA is 41:8
`define HSM_TMR_W 20
`define HSM_TMR_CHARGE 20'h0_0029
`define HSM_TMR_DISCH 20'h0_0008
`define HSM_TMR_TMO_DEF 41000
// Retry cycle count
`define HSM_RETRY_W 7
`define HSM_RETRY_LAST 7'h3F
// Counter widths
`define HSM_PD_W 16
`define HSM_DEGL_W 24
// Synchroniser depth
`define HSM_SYNC_W 3

`endif

// *** core/hsm_pkg.sv ***
/*
 * Types of the hot swap mode sequencer: modes, variants, state records.
 * Assumes hsm_params.svh on the include path.
 */
`include "hsm_params.svh"

package hsm_pkg;

    // Operating modes
    typedef enum logic [2:0] {
        HSM_INRUSH  = 3'b000,
        HSM_REGULAR = 3'b001,
        HSM_FAULT   = 3'b010,
        HSM_PULSE   = 3'b011,
        HSM_LATCHED = 3'b100,
        HSM_RETRY   = 3'b101
    } hsm_mode_t;

    // Static response variant
    typedef enum logic [1:0] {
        HSM_VAR_LATCH     = 2'b00,
        HSM_VAR_RETRY     = 2'b01,
        HSM_VAR_FASTLATCH = 2'b10
    } hsm_variant_t;

    // Whole sequencer state
    typedef struct packed {
        hsm_mode_t mode;
        hsm_mode_t after_pulse;
        logic [`HSM_TMR_W-1:0] inrush_timer;
        logic [`HSM_TMR_W-1:0] overcurrent_timer;
        logic [`HSM_PD_W-1:0] pulse_cnt;
        logic [`HSM_RETRY_W-1:0] retry_cnt;
        logic retry_charging;
        logic restarted_once;
        logic timed_out;
        logic oc_tripped;
        logic enable_prev;
        logic gate_drive;
        logic gate_regulate;
        logic gate_strong_pd;
    } hsm_state_t;

    // Deglitch filter state
    typedef struct packed {
        logic [`HSM_DEGL_W-1:0] cnt;
        logic level;
    } hsm_degl_t;

endpackage : hsm_pkg

// *** core/hsm_sequencer.sv ***
/*
 * Hot swap mode sequencer: inrush, regular, fault, pull-down pulse,
 * latched and retry modes, both protection timers, power-good and fault
 * indications. Assumes comparator levels from an analog front end,
 * asynchronous to clk, and a gate driver that obeys the three gate controls.
 */
`timescale 1ns/1ps
`include "hsm_params.svh"

module hsm_sequencer
    import hsm_pkg::*;
#(
    parameter hsm_variant_t VARIANT = HSM_VAR_LATCH, // RULE_19
    parameter int unsigned INRUSH_TMO = `HSM_TMR_TMO_DEF,
    parameter int unsigned FAULT_TMO = `HSM_TMR_TMO_DEF,
    parameter int unsigned PULSE_CYC = `HSM_PD_PULSE_CYC,
    parameter int unsigned PG_RISE_CYC = `HSM_PG_RISE_CYC,
    parameter int unsigned PG_FALL_CYC = `HSM_PG_FALL_CYC,
    parameter int unsigned FLT_DEGL_CYC = `HSM_FLT_DEGL_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Comparator levels from the analog front end
    input wire logic switch_enable_in,
    input wire logic overvoltage_in,
    input wire logic over_current_limit,
    input wire logic fast_trip_level,
    input wire logic limiting_active,
    input wire logic vds_below_low,
    input wire logic vds_above_high,
    input wire logic over_temp_shutdown,
    input wire logic current_monitor_level,
    // Static board strap
    input wire logic timers_tied,
    // Gate controls
    output logic gate_drive,
    output logic gate_regulate,
    output logic gate_strong_pd,
    // Status
    output logic power_good_out,
    output logic fault_out_n,
    output hsm_mode_t mode_out,
    output logic [`HSM_TMR_W-1:0] inrush_timer,
    output logic [`HSM_TMR_W-1:0] overcurrent_timer
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    logic [8:0] raw_in;
    logic [8:0] syn;
    logic en_s;
    logic ov_s;
    logic oc_s;
    logic ft_s;
    logic lim_s;
    logic vlo_s;
    logic vhi_s;
    logic ot_s;
    logic current_monitor_level_s;

    assign raw_in = {switch_enable_in, overvoltage_in, over_current_limit, fast_trip_level, limiting_active,
                     vds_below_low, vds_above_high, over_temp_shutdown, current_monitor_level};

    // Every comparator level is retimed before any decision sees it
    hsm_sync #(.WIDTH(9)) u_sync ( // RULE_20
        .clk(clk),
        .srst(srst),
        .async_in(raw_in),
        .sync_out(syn)
    );

    assign {en_s, ov_s, oc_s, ft_s, lim_s, vlo_s, vhi_s, ot_s, current_monitor_level_s} = syn;

    ////////////////////////////////////////////////////////////////////////
    // Timer model

    localparam logic [`HSM_TMR_W-1:0] INR_THR = `HSM_TMR_W'(INRUSH_TMO);
    localparam logic [`HSM_TMR_W-1:0] FLT_THR = `HSM_TMR_W'(FAULT_TMO);
    localparam logic [`HSM_PD_W-1:0] PULSE_LAST = `HSM_PD_W'(PULSE_CYC - 1);

    // Charge saturates at threshold, discharge floors at zero
    function automatic logic [`HSM_TMR_W-1:0] tmr_next(
        input logic [`HSM_TMR_W-1:0] val,
        input logic charge,
        input logic [`HSM_TMR_W-1:0] thr,
        input logic [`HSM_TMR_W-1:0] dstep
    );
        if (charge) begin
            tmr_next = (thr - val < `HSM_TMR_CHARGE) ? thr : val + `HSM_TMR_CHARGE;
        end else begin
            tmr_next = (val < dstep) ? '0 : val - dstep;
        end
    endfunction : tmr_next

    // Timeout ends in retry for the retry variant, latched otherwise
    function automatic hsm_mode_t tmo_mode(input hsm_variant_t v);
        tmo_mode = (v == HSM_VAR_RETRY) ? HSM_RETRY : HSM_LATCHED;
    endfunction : tmo_mode

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencer

    hsm_state_t q;
    hsm_state_t d;
    logic en_rise;
    logic shut_off;
    logic [`HSM_TMR_W-1:0] retry_dstep;

    // Tied timers double the retry discharge step, halving each discharge phase
    assign retry_dstep = timers_tied ? (`HSM_TMR_DISCH << 1) : `HSM_TMR_DISCH;
    assign en_rise = en_s && !q.enable_prev;
    assign shut_off = !en_s || ov_s || ot_s;

    always_comb begin
        d = q;
        d.enable_prev = en_s;
        d.gate_regulate = 1'b0;
        d.gate_strong_pd = 1'b0;
        d.gate_drive = 1'b0;
        d.inrush_timer = tmr_next(q.inrush_timer, 1'b0, INR_THR, `HSM_TMR_DISCH); // RULE_01
        d.overcurrent_timer = tmr_next(q.overcurrent_timer, 1'b0, FLT_THR, `HSM_TMR_DISCH); // RULE_02
        case (q.mode)
            HSM_INRUSH: begin
                if (!shut_off) begin
                    d.gate_drive = 1'b1; // RULE_12
                    d.gate_regulate = 1'b1;
                    d.inrush_timer = tmr_next(q.inrush_timer, lim_s, INR_THR, `HSM_TMR_DISCH); // RULE_01
                    if (q.inrush_timer >= INR_THR) begin
                        d.gate_drive = 1'b0; // RULE_12
                        d.gate_regulate = 1'b0;
                        d.timed_out = 1'b1; // RULE_03
                        d.mode = tmo_mode(VARIANT); // RULE_03 RULE_12
                        d.retry_cnt = '0;
                        d.retry_charging = 1'b1;
                    end else if (!lim_s && vlo_s) begin
                        d.mode = HSM_REGULAR;
                    end
                end
            end
            HSM_REGULAR, HSM_FAULT: begin
                d.gate_drive = 1'b1; // RULE_13
                if (q.mode == HSM_FAULT) begin
                    d.overcurrent_timer = tmr_next(q.overcurrent_timer, oc_s, FLT_THR, `HSM_TMR_DISCH); // RULE_02
                end
                if (shut_off) begin
                    d.gate_drive = 1'b0; // RULE_17
                    d.mode = HSM_INRUSH;
                end else if (ft_s) begin
                    // Fast trip skips the timers entirely
                    d.gate_drive = 1'b0; // RULE_04
                    d.gate_strong_pd = 1'b1; // RULE_06
                    d.pulse_cnt = '0;
                    d.mode = HSM_PULSE;
                    if (VARIANT == HSM_VAR_FASTLATCH) begin
                        d.after_pulse = HSM_LATCHED; // RULE_05 RULE_07
                    end else if (VARIANT == HSM_VAR_LATCH && q.restarted_once) begin
                        d.after_pulse = HSM_LATCHED; // RULE_05
                    end else begin
                        d.after_pulse = HSM_INRUSH; // RULE_05 RULE_07
                        d.restarted_once = 1'b1;
                    end
                end else if (q.mode == HSM_FAULT && q.overcurrent_timer >= FLT_THR) begin
                    d.gate_drive = 1'b0;
                    d.timed_out = 1'b1; // RULE_03
                    d.oc_tripped = 1'b1;
                    d.mode = tmo_mode(VARIANT); // RULE_14
                    d.retry_cnt = '0;
                    d.retry_charging = 1'b1;
                end else if (q.mode == HSM_REGULAR && oc_s) begin
                    d.mode = HSM_FAULT; // RULE_13
                end else if (q.mode == HSM_FAULT && !oc_s) begin
                    d.mode = HSM_REGULAR; // RULE_14
                end
            end
            HSM_PULSE: begin
                d.gate_strong_pd = 1'b1; // RULE_06
                d.pulse_cnt = q.pulse_cnt + 1'b1;
                // Entry cycle counts, so the pulse spans exactly PULSE_CYC cycles
                if (q.pulse_cnt >= PULSE_LAST) begin
                    d.gate_strong_pd = 1'b0;
                    d.mode = q.after_pulse; // RULE_07
                    d.timed_out = (q.after_pulse == HSM_LATCHED) ? 1'b1 : q.timed_out;
                end
            end
            HSM_LATCHED: begin
                // Held off until the controller gives an enable edge
                if (en_rise) begin
                    d.mode = HSM_INRUSH; // RULE_15
                    d.inrush_timer = '0;
                    d.overcurrent_timer = '0;
                    d.timed_out = 1'b0;
                    d.oc_tripped = 1'b0;
                    d.restarted_once = 1'b0;
                end
            end
            HSM_RETRY: begin
                if (q.retry_charging) begin
                    d.inrush_timer = tmr_next(q.inrush_timer, 1'b1, INR_THR, retry_dstep); // RULE_16
                    d.retry_charging = (q.inrush_timer < INR_THR);
                end else begin
                    d.inrush_timer = tmr_next(q.inrush_timer, 1'b0, INR_THR, retry_dstep); // RULE_16
                    if (q.inrush_timer == '0) begin
                        d.retry_charging = 1'b1;
                        d.retry_cnt = q.retry_cnt + 1'b1;
                        if (q.retry_cnt == `HSM_RETRY_LAST) begin
                            d.mode = HSM_INRUSH; // RULE_16
                            d.timed_out = 1'b0;
                            d.oc_tripped = 1'b0;
                        end
                    end
                end
            end
            default: begin
                d.mode = HSM_INRUSH;
            end
        endcase
    end

    // State register; reset lands in inrush with the gate off
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0; // RULE_11
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status indications

    logic pg_target;
    logic flt_target;
    logic flt_level;

    // Clear terms win over the set terms while power-good is up
    assign pg_target = power_good_out ? !(!en_s || vhi_s || q.oc_tripped) : (en_s && vlo_s); // RULE_08 RULE_09
    assign flt_target = (!en_s && current_monitor_level_s) || q.timed_out || ot_s; // RULE_10

    hsm_deglitch #(.RISE_CYC(PG_RISE_CYC), .FALL_CYC(PG_FALL_CYC)) u_pg_degl ( // RULE_08 RULE_09
        .clk(clk),
        .srst(srst),
        .target(pg_target),
        .level(power_good_out)
    );

    hsm_deglitch #(.RISE_CYC(FLT_DEGL_CYC), .FALL_CYC(FLT_DEGL_CYC)) u_flt_degl ( // RULE_18
        .clk(clk),
        .srst(srst),
        .target(flt_target),
        .level(flt_level)
    );

    // Outputs straight from the state record, fault pin from its deglitch filter
    assign fault_out_n = !flt_level; // RULE_10
    assign gate_drive = q.gate_drive;
    assign gate_regulate = q.gate_regulate;
    assign gate_strong_pd = q.gate_strong_pd;
    assign mode_out = q.mode;
    assign inrush_timer = q.inrush_timer;
    assign overcurrent_timer = q.overcurrent_timer;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_fast_trip_reg;
        q.mode == HSM_REGULAR && ft_s && !shut_off;
    endsequence

    sequence s_pulse_end;
        q.mode == HSM_PULSE && q.pulse_cnt >= PULSE_LAST;
    endsequence

    a_inrush_charge: assert property ((q.mode == HSM_INRUSH && !shut_off && lim_s
        && q.inrush_timer + `HSM_TMR_CHARGE < INR_THR) |=> inrush_timer == $past(inrush_timer) + `HSM_TMR_CHARGE) // RULE_01
        else $error("inrush timer did not charge while limiting");

    a_fault_charge: assert property ((q.mode == HSM_FAULT && oc_s && !shut_off && !ft_s
        && q.overcurrent_timer + `HSM_TMR_CHARGE < FLT_THR) |=> overcurrent_timer > $past(overcurrent_timer)) // RULE_02
        else $error("fault timer did not charge over limit");

    a_regular_timer: assert property ((q.mode == HSM_REGULAR && q.overcurrent_timer != '0)
        |=> overcurrent_timer < $past(overcurrent_timer)) // RULE_13
        else $error("fault timer not discharging in regular mode");

    a_timeout_mode: assert property ((q.mode == HSM_INRUSH && !shut_off && q.inrush_timer >= INR_THR)
        |=> mode_out == tmo_mode(VARIANT) && !gate_drive && q.timed_out) // RULE_03
        else $error("inrush timeout went to the wrong mode");

    a_fast_trip_pd: assert property (s_fast_trip_reg |=> gate_strong_pd && !gate_drive
        && mode_out == HSM_PULSE) // RULE_06
        else $error("fast trip did not start strong pull-down");

    a_pulse_length: assert property (gate_strong_pd |-> q.pulse_cnt <= PULSE_LAST) // RULE_06
        else $error("strong pull-down pulse overran");

    a_pulse_target: assert property (s_pulse_end |=> mode_out == $past(q.after_pulse)
        && !gate_strong_pd) // RULE_07
        else $error("wrong mode after pull-down pulse");

    a_latched_hold: assert property ((q.mode == HSM_LATCHED && !en_rise)
        |=> mode_out == HSM_LATCHED && !gate_drive) // RULE_15
        else $error("left latched mode without enable edge");

    a_latched_exit: assert property ((q.mode == HSM_LATCHED && en_rise)
        |=> mode_out == HSM_INRUSH && inrush_timer == '0) // RULE_15
        else $error("enable edge did not restart inrush");

    a_retry_exit: assert property ((q.mode == HSM_RETRY && !q.retry_charging && q.inrush_timer == '0
        && q.retry_cnt == `HSM_RETRY_LAST) |=> mode_out == HSM_INRUSH) // RULE_16
        else $error("retry did not return to inrush");

    a_ov_gate_off: assert property (ov_s |=> !gate_drive) // RULE_17
        else $error("gate on while overvoltage");

    a_reset_inrush: assert property (disable iff (1'b0) $past(srst) |-> mode_out == HSM_INRUSH) // RULE_11
        else $error("not in inrush after reset");

    a_fault_pin: assert property ($fell(fault_out_n) |-> $past(flt_target)) // RULE_10
        else $error("fault output fell without a cause");

endmodule : hsm_sequencer

// *** core/hsm_sync.sv ***
/*
 * Three-stage input synchroniser; a change counts once stages two and
 * three agree. Assumes inputs asynchronous to clk.
 */
`timescale 1ns/1ps

module hsm_sync
    import hsm_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;

    // Stage one feeds stage two only; agreement filters a lone bad sample
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    out_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign sync_out = out_q;

endmodule : hsm_sync

// *** verification/hsm_fet_model.sv ***
/*
 * Behavioural pass transistor and comparator front end of the sequencer.
 * Assumes the sequencer gate controls on clk; the bench commands a short.
 */
`timescale 1ns/1ps

module hsm_fet_model (
    // Clock
    input wire logic clk,
    // Gate controls and bench command
    input wire logic gate_drive,
    input wire logic gate_regulate,
    input wire logic stick_limit,
    // Comparator levels
    output logic limiting_active,
    output logic vds_below_low,
    output logic vds_above_high,
    output logic current_monitor_level
);
    logic [1:0] ramp_q;

    // Output charges over three cycles while the gate is on
    always @(posedge clk) begin
        ramp_q <= !gate_drive ? 2'h0 : (ramp_q == 2'h3 ? ramp_q : ramp_q + 2'h1);
    end

    // A stuck limit models a start into a short, so inrush ends only in a timeout
    assign limiting_active = gate_regulate & (stick_limit | ramp_q != 2'h3);
    assign vds_below_low = gate_drive & !limiting_active & ramp_q == 2'h3;
    assign vds_above_high = !vds_below_low;
    assign current_monitor_level = gate_drive;
endmodule : hsm_fet_model

// *** verification/hsm_sequencer_tb.sv ***
/*
 * Self-checking bench of the hot swap mode sequencer, latch and retry variants.
 * Assumes shortened counts; inputs change on the falling edge.
 */
`timescale 1ns/1ps
`include "hsm_params.svh"

module hsm_sequencer_tb
    import hsm_pkg::*;
;
    logic clk, srst, en, ov, oc, ft, ot, stick, lim, vlo, vhi, mon, tied;
    logic gd_r, gr_r, lim_r, vlo_r, vhi_r, mon_r, fn_r;
    hsm_mode_t mode_r;
    int t0;
    logic gate_drive, gate_regulate, gate_strong_pd, power_good_out, fault_out_n;
    hsm_mode_t mode_out;
    logic [`HSM_TMR_W-1:0] inrush_timer, overcurrent_timer;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int n;

    ////////////////////////////////////////////////////////////////
    // Design and far side
    hsm_sequencer #(.VARIANT(HSM_VAR_LATCH), .INRUSH_TMO(400), .FAULT_TMO(800), .PULSE_CYC(10),
        .PG_RISE_CYC(20), .PG_FALL_CYC(40), .FLT_DEGL_CYC(30)) dut_u (
        .clk(clk), .srst(srst), .switch_enable_in(en), .overvoltage_in(ov),
        .over_current_limit(oc), .fast_trip_level(ft), .limiting_active(lim),
        .vds_below_low(vlo), .vds_above_high(vhi), .over_temp_shutdown(ot),
        .current_monitor_level(mon), .timers_tied(tied), .gate_drive(gate_drive),
        .gate_regulate(gate_regulate), .gate_strong_pd(gate_strong_pd),
        .power_good_out(power_good_out), .fault_out_n(fault_out_n), .mode_out(mode_out),
        .inrush_timer(inrush_timer), .overcurrent_timer(overcurrent_timer));
    hsm_fet_model fet_u (.clk(clk), .gate_drive(gate_drive), .gate_regulate(gate_regulate),
        .stick_limit(stick), .limiting_active(lim), .vds_below_low(vlo),
        .vds_above_high(vhi), .current_monitor_level(mon));
    // Retry variant on the same stimulus, with its own transistor
    hsm_sequencer #(.VARIANT(HSM_VAR_RETRY), .INRUSH_TMO(400), .FAULT_TMO(800), .PULSE_CYC(10),
        .PG_RISE_CYC(20), .PG_FALL_CYC(40), .FLT_DEGL_CYC(30)) dut_retry (
        .clk(clk), .srst(srst), .switch_enable_in(en), .overvoltage_in(ov),
        .over_current_limit(oc), .fast_trip_level(ft), .limiting_active(lim_r),
        .vds_below_low(vlo_r), .vds_above_high(vhi_r), .over_temp_shutdown(ot),
        .current_monitor_level(mon_r), .timers_tied(tied), .gate_drive(gd_r),
        .gate_regulate(gr_r), .gate_strong_pd(), .power_good_out(), .fault_out_n(fn_r),
        .mode_out(mode_r), .inrush_timer(), .overcurrent_timer());
    hsm_fet_model fet_r (.clk(clk), .gate_drive(gd_r), .gate_regulate(gr_r),
        .stick_limit(stick), .limiting_active(lim_r), .vds_below_low(vlo_r),
        .vds_above_high(vhi_r), .current_monitor_level(mon_r));

    ////////////////////////////////////////////////////////////////
    // Checking and pacing tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Bounded wait for a mode, then compare it
    task automatic go(input hsm_mode_t m);
        int k;
        k = 0;
        while (mode_out !== m && k < 400) begin
            k++;
            @(negedge clk);
        end
        chk(mode_out, m);
    endtask : go

    // Enable rising edge is the only way out of latched
    task automatic toggle_en;
        en = 1'b0;
        repeat (8) @(negedge clk);
        en = 1'b1;
    endtask : toggle_en

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Scenarios
    initial begin
        srst = 1'b1;
        en = 1'b0;
        ov = 1'b0;
        oc = 1'b0;
        ft = 1'b0;
        ot = 1'b0;
        stick = 1'b0;
        tied = 1'b0;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        chk(mode_out, HSM_INRUSH);
        chk({gate_drive, power_good_out, fault_out_n}, 3'h1);
        en = 1'b1;
        go(HSM_REGULAR);
        repeat (10) @(negedge clk);
        chk(power_good_out, 1'b0);
        repeat (25) @(negedge clk);
        chk(power_good_out, 1'b1);
        chk({gate_drive, gate_regulate, inrush_timer}, {2'h2, 20'h0_0000});
        $display("test startup done");
        oc = 1'b1;
        go(HSM_FAULT);
        repeat (2) @(negedge clk);
        chk(overcurrent_timer != 0, 1'b1);
        oc = 1'b0;
        go(HSM_REGULAR);
        ov = 1'b1;
        go(HSM_INRUSH);
        chk(gate_drive, 1'b0);
        ov = 1'b0;
        go(HSM_REGULAR);
        $display("test overcurrent done");
        ft = 1'b1;
        go(HSM_PULSE);
        chk({gate_drive, gate_strong_pd}, 2'h1);
        ft = 1'b0;
        n = 0;
        while (gate_strong_pd === 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
        end
        chk(n, 10);
        go(HSM_INRUSH);
        go(HSM_REGULAR);
        ft = 1'b1;
        go(HSM_LATCHED);
        ft = 1'b0;
        chk({gate_drive, fault_out_n}, 2'h1);
        repeat (40) @(negedge clk);
        chk({gate_drive, fault_out_n}, 2'h0);
        toggle_en();
        go(HSM_INRUSH);
        go(HSM_REGULAR);
        repeat (45) @(negedge clk);
        chk({fault_out_n, power_good_out}, 2'h3);
        $display("test fast trip done");
        // Over-temperature drops the gate and raises the fault after deglitch
        ot = 1'b1;
        go(HSM_INRUSH);
        repeat (40) @(negedge clk);
        chk({gate_drive, gate_regulate, fault_out_n}, 3'h0);
        ot = 1'b0;
        go(HSM_REGULAR);
        oc = 1'b1;
        go(HSM_LATCHED);
        t0 = cyc;
        oc = 1'b0;
        // Fault timer sits at threshold and bleeds off eight per cycle
        repeat (110) @(negedge clk);
        chk({power_good_out, fault_out_n, overcurrent_timer}, 22'h0);
        chk({mode_r, fn_r}, {HSM_RETRY, 1'b0});
        stick = 1'b1;
        toggle_en();
        go(HSM_INRUSH);
        repeat (6) @(negedge clk);
        chk(inrush_timer != 0, 1'b1);
        chk(gate_regulate, 1'b1);
        go(HSM_LATCHED);
        repeat (60) @(negedge clk);
        chk({gate_drive, inrush_timer}, 21'h0);
        $display("test timeout done");
        // Sixty-four rounds of at least fifty discharge cycles each
        n = 0;
        while (mode_r === HSM_RETRY && n < 5000) begin
            n++;
            @(negedge clk);
        end
        chk(mode_r, HSM_INRUSH);
        chk(cyc - t0 >= 3200 && cyc - t0 <= 4200, 1'b1);
        $display("test retry done");
        give_verdict();
    end
endmodule : hsm_sequencer_tb
